/* hw/vic_pkg.sv */
// Constants shared by the vectored interrupt controller
package vic_pkg;

    localparam int VIC_NSRC = 10;

    // Register indices on the special-function register port
    localparam logic [2:0] VIC_REG_REQ_LOW_A = 3'h0;
    localparam logic [2:0] VIC_REG_REQ_LOW_B = 3'h1;
    localparam logic [2:0] VIC_REG_REQ_HIGH = 3'h2;
    localparam logic [2:0] VIC_REG_MASK_LOW_A = 3'h3;
    localparam logic [2:0] VIC_REG_MASK_LOW_B = 3'h4;
    localparam logic [2:0] VIC_REG_MASK_HIGH = 3'h5;
    localparam int VIC_NREG = 6;
    localparam int VIC_MASK_BASE = 3;

    localparam logic [7:0] VIC_REQ_RESET = 8'h00;
    localparam logic [7:0] VIC_MASK_RESET = 8'hff;

    // Source order is the default priority: index 0 wins
    localparam int VIC_SRC_WDT = 0;
    localparam int VIC_SRC_PIN1 = 1;

    // Flag register index and bit position of each source
    localparam int VIC_SRC_REG [VIC_NSRC] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2};
    localparam int VIC_SRC_BIT [VIC_NSRC] = '{0, 2, 3, 4, 2, 3, 4, 2, 3, 4};
    localparam int VIC_WDT_BIT = 0;

    localparam logic [15:0] VIC_VEC [VIC_NSRC] = '{
        16'h0004, 16'h0008, 16'h000a, 16'h000c, 16'h0018,
        16'h001a, 16'h001c, 16'h0028, 16'h002a, 16'h002c};
    localparam logic [15:0] VIC_VEC_NMI = 16'h0004;
    localparam logic [15:0] VIC_VEC_BRK = 16'h003e;

    // Least clocks from request to service start, per group
    localparam int VIC_MIN_CLK_HIGH = 7;
    localparam int VIC_MIN_CLK_LOW = 8;
    localparam logic [3:0] VIC_WAIT_HIGH = 4'(VIC_MIN_CLK_HIGH - 1);
    localparam logic [3:0] VIC_WAIT_LOW = 4'(VIC_MIN_CLK_LOW - 1);

    typedef enum logic [1:0] {
        VIC_ST_IDLE = 2'b00,
        VIC_ST_WAIT = 2'b01,
        VIC_ST_REQ = 2'b10
    } vic_state_t;

endpackage : vic_pkg

/* hw/vic_pin_edge.sv */
// Synchronised edge detector for one external request pin
`timescale 1ns/1ps
module vic_pin_edge
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic pin_in,
    input wire logic rise_en_in,
    input wire logic fall_en_in,
    output logic edge_out
);

    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [2:0] arm_q;

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            arm_q <= 3'h0;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end

    // Pad level includes the port driver, so output toggles also fire
    // Blind until prev holds the pad level, so a pin high at reset is no edge
    assign edge_out = arm_q[2] & ((rise_en_in & sync_q & ~prev_q) |
                      (fall_en_in & ~sync_q & prev_q));

endmodule : vic_pin_edge

/* hw/vic_controller.sv */
// Vectored interrupt controller: flags, masks, arbitration, vectors
`timescale 1ns/1ps
module vic_controller
    import vic_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic watchdog_overflow_irq_in,
    input wire logic wdt_mode1_in,
    input wire logic [2:0] pin_edge_irq_in,
    input wire logic [2:0] pin_rise_en_in,
    input wire logic [2:0] pin_fall_en_in,
    input wire logic serial_rx_error_irq_in,
    input wire logic serial_rx_done_irq_in,
    input wire logic three_wire_done_irq_in,
    input wire logic serial_tx_done_irq_in,
    input wire logic conversion_done_irq_in,
    input wire logic timer_a_match_irq_in,
    input wire logic timer_b_match_irq_in,
    input wire logic [VIC_NSRC-1:0] source_priority_flag_in,
    input wire logic global_irq_enable_in,
    input wire logic in_service_priority_in,
    input wire logic software_break_instr_in,
    input wire logic irq_ack_in,
    input wire logic nmi_return_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_word_in,
    input wire logic reg_bit_in,
    input wire logic [2:0] reg_bit_idx_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic irq_req_out,
    output logic irq_nmi_out,
    output logic [15:0] vector_out,
    output logic accept_out,
    output logic ie_clear_out,
    output logic isp_load_out,
    output logic isp_value_out,
    output logic standby_release_out
);

    logic [7:0] flag_q [3];
    logic [7:0] mask_q [3];
    logic [7:0] wen [VIC_NREG];
    logic [7:0] wval [VIC_NREG];
    logic [7:0] hw_byte [3];
    logic [7:0] ack_byte [3];
    logic [VIC_NSRC-1:0] hw_src;
    logic [VIC_NSRC-1:0] src_flag;
    logic [VIC_NSRC-1:0] src_mask;
    logic [VIC_NSRC-1:0] acc;
    logic [VIC_NSRC-1:0] wake;
    logic [2:0] pin_edge;
    logic nmi_pend_q;
    logic nmi_busy_q;
    logic nmi_avail;
    logic nmi_set;
    vic_state_t state_q;
    vic_state_t state_d;
    logic [3:0] src_q;
    logic [3:0] src_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic nmi_q;
    logic nmi_d;
    logic win_valid;
    logic [3:0] win_src;
    logic ack_take;
    logic brk_take;
    logic [15:0] vector_q;
    logic accept_q;
    logic ie_clear_q;
    logic isp_load_q;
    logic isp_value_q;
    logic standby_q;
    logic [15:0] rdata_q;

    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++)
        begin : g_pin
            vic_pin_edge u_edge
            (
                .ref_clk_in(ref_clk_in),
                .nrst_in(nrst_in),
                .pin_in(pin_edge_irq_in[gp]),
                .rise_en_in(pin_rise_en_in[gp]),
                .fall_en_in(pin_fall_en_in[gp]),
                .edge_out(pin_edge[gp])
            );
        end
    endgenerate

    // Overflow goes to exactly one path depending on watchdog mode
    assign nmi_set = watchdog_overflow_irq_in & wdt_mode1_in;
    assign hw_src = {timer_b_match_irq_in, timer_a_match_irq_in,
                     conversion_done_irq_in,
                     serial_tx_done_irq_in,
                     serial_rx_done_irq_in | three_wire_done_irq_in,
                     serial_rx_error_irq_in,
                     pin_edge,
                     watchdog_overflow_irq_in & ~wdt_mode1_in};

    genvar gs;
    generate
        for (gs = 0; gs < VIC_NSRC; gs++)
        begin : g_src
            localparam int R = VIC_SRC_REG[gs];
            localparam int B = VIC_SRC_BIT[gs];
            assign src_flag[gs] = flag_q[R][B];
            assign src_mask[gs] = mask_q[R][B];
            assign wake[gs] = src_flag[gs] & ~src_mask[gs] &
                              ~(gs == VIC_SRC_WDT && wdt_mode1_in);
            assign acc[gs] = wake[gs] & global_irq_enable_in &
                             (~source_priority_flag_in[gs] |
                              in_service_priority_in);
        end
    endgenerate

    // Register write decode: byte, bit, or low pair as one word
    always_comb
    begin
        for (int r = 0; r < VIC_NREG; r++)
        begin
            wen[r] = 8'h00;
            wval[r] = 8'h00;
        end
        if (reg_wr_in && int'(reg_sel_in) < VIC_NREG)
        begin
            if (reg_bit_in)
            begin
                wen[reg_sel_in] = 8'h01 << reg_bit_idx_in;
                wval[reg_sel_in] = {8{reg_wdata_in[0]}};
            end
            else
            begin
                wen[reg_sel_in] = 8'hff;
                wval[reg_sel_in] = reg_wdata_in[7:0];
                if (reg_word_in && (reg_sel_in == VIC_REG_REQ_LOW_A ||
                    reg_sel_in == VIC_REG_MASK_LOW_A))
                begin
                    wen[reg_sel_in + 3'h1] = 8'hff;
                    wval[reg_sel_in + 3'h1] = reg_wdata_in[15:8];
                end
            end
        end
        // Watchdog request bit is frozen while the watchdog is an NMI
        if (wdt_mode1_in)
        begin
            wen[VIC_REG_REQ_LOW_A][VIC_WDT_BIT] = 1'b0;
        end
    end

    // Hardware sets and acknowledge clears, spread onto flag bytes
    always_comb
    begin
        for (int r = 0; r < 3; r++)
        begin
            hw_byte[r] = 8'h00;
            ack_byte[r] = 8'h00;
        end
        for (int i = 0; i < VIC_NSRC; i++)
        begin
            hw_byte[VIC_SRC_REG[i]][VIC_SRC_BIT[i]] = hw_src[i];
            ack_byte[VIC_SRC_REG[i]][VIC_SRC_BIT[i]] =
                ack_take & ~nmi_q & (int'(src_q) == i);
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int r = 0; r < 3; r++)
            begin
                flag_q[r] <= VIC_REQ_RESET;
            end
        end
        else
        begin
            for (int r = 0; r < 3; r++)
            begin
                flag_q[r] <= (((flag_q[r] & ~wen[r]) | (wval[r] & wen[r]))
                              & ~ack_byte[r]) | hw_byte[r];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int r = 0; r < 3; r++)
            begin
                mask_q[r] <= VIC_MASK_RESET;
            end
        end
        else
        begin
            for (int r = 0; r < 3; r++)
            begin
                mask_q[r] <= (mask_q[r] & ~wen[r + VIC_MASK_BASE]) |
                    (wval[r + VIC_MASK_BASE] & wen[r + VIC_MASK_BASE]);
            end
        end
    end

    // Non-maskable: one extra request is remembered during its service
    assign nmi_avail = nmi_pend_q & ~nmi_busy_q;

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            nmi_pend_q <= 1'b0;
            nmi_busy_q <= 1'b0;
        end
        else
        begin
            if (nmi_set)
            begin
                nmi_pend_q <= 1'b1;
            end
            else if (ack_take && nmi_q)
            begin
                nmi_pend_q <= 1'b0;
            end
            if (ack_take && nmi_q)
            begin
                nmi_busy_q <= 1'b1;
            end
            else if (nmi_return_in)
            begin
                nmi_busy_q <= 1'b0;
            end
        end
    end

    // High group first, then lowest index within the group
    always_comb
    begin
        win_valid = 1'b0;
        win_src = 4'h0;
        for (int i = VIC_NSRC - 1; i >= 0; i--)
        begin
            if (acc[i] && source_priority_flag_in[i])
            begin
                win_valid = 1'b1;
                win_src = 4'(i);
            end
        end
        for (int i = VIC_NSRC - 1; i >= 0; i--)
        begin
            if (acc[i] && !source_priority_flag_in[i])
            begin
                win_valid = 1'b1;
                win_src = 4'(i);
            end
        end
    end

    // A break is instruction-driven; it preempts an ack in the same cycle
    assign brk_take = software_break_instr_in;
    assign ack_take = (state_q == VIC_ST_REQ) & irq_ack_in & ~brk_take;

    always_comb
    begin
        state_d = state_q;
        src_d = src_q;
        cnt_d = cnt_q;
        nmi_d = nmi_q;
        unique case (state_q)
            VIC_ST_IDLE:
            begin
                if (nmi_avail)
                begin
                    state_d = VIC_ST_REQ;
                    nmi_d = 1'b1;
                end
                else if (win_valid)
                begin
                    state_d = VIC_ST_WAIT;
                    src_d = win_src;
                    nmi_d = 1'b0;
                    cnt_d = source_priority_flag_in[win_src] ?
                            VIC_WAIT_LOW : VIC_WAIT_HIGH;
                end
            end
            VIC_ST_WAIT:
            begin
                if (nmi_avail)
                begin
                    state_d = VIC_ST_REQ;
                    nmi_d = 1'b1;
                end
                else if (!acc[src_q])
                begin
                    state_d = VIC_ST_IDLE;
                end
                else if (cnt_q == 4'h1)
                begin
                    state_d = VIC_ST_REQ;
                end
                else
                begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            VIC_ST_REQ:
            begin
                if (ack_take)
                begin
                    state_d = VIC_ST_IDLE;
                end
                else if (!nmi_q && nmi_avail)
                begin
                    nmi_d = 1'b1;
                end
                else if (!nmi_q && !acc[src_q])
                begin
                    state_d = VIC_ST_IDLE;
                end
            end
            default:
            begin
                state_d = VIC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= VIC_ST_IDLE;
            src_q <= 4'h0;
            cnt_q <= 4'h0;
            nmi_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            src_q <= src_d;
            cnt_q <= cnt_d;
            nmi_q <= nmi_d;
        end
    end

    // Vector holds through the accept pulse so the core can load it
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            vector_q <= 16'h0000;
        end
        else if (brk_take)
        begin
            vector_q <= VIC_VEC_BRK;
        end
        else if (!ack_take && state_d == VIC_ST_REQ)
        begin
            vector_q <= nmi_d ? VIC_VEC_NMI : VIC_VEC[src_d];
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            accept_q <= 1'b0;
            ie_clear_q <= 1'b0;
            isp_load_q <= 1'b0;
            isp_value_q <= 1'b1;
        end
        else
        begin
            accept_q <= ack_take | brk_take;
            ie_clear_q <= ack_take | brk_take;
            isp_load_q <= ack_take;
            if (ack_take)
            begin
                // NMI service forces the high-priority in-service state
                isp_value_q <= nmi_q ? 1'b0 :
                               source_priority_flag_in[src_q];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            standby_q <= 1'b0;
        end
        else
        begin
            standby_q <= nmi_pend_q | (|wake);
        end
    end

    // Read data is registered; watchdog request bit reads as 0 in mode 1
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdata_q <= 16'h0000;
        end
        else if (reg_rd_in)
        begin
            rdata_q <= 16'h0000;
            if (reg_sel_in < VIC_REG_MASK_LOW_A)
            begin
                rdata_q[7:0] <= flag_q[reg_sel_in[1:0]];
                if (reg_sel_in == VIC_REG_REQ_LOW_A)
                begin
                    rdata_q[VIC_WDT_BIT] <= flag_q[0][VIC_WDT_BIT] &
                                            ~wdt_mode1_in;
                    if (reg_word_in)
                    begin
                        rdata_q[15:8] <= flag_q[1];
                    end
                end
            end
            else if (reg_sel_in <= VIC_REG_MASK_HIGH)
            begin
                rdata_q[7:0] <= mask_q[2'(reg_sel_in - 3'h3)];
                if (reg_sel_in == VIC_REG_MASK_LOW_A && reg_word_in)
                begin
                    rdata_q[15:8] <= mask_q[1];
                end
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_req_out = (state_q == VIC_ST_REQ);
    assign irq_nmi_out = nmi_q & (state_q == VIC_ST_REQ);
    assign vector_out = vector_q;
    assign accept_out = accept_q;
    assign ie_clear_out = ie_clear_q;
    assign isp_load_out = isp_load_q;
    assign isp_value_out = isp_value_q;
    assign standby_release_out = standby_q;

endmodule : vic_controller

/* test/vic_properties.sv */
// Port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vic_props
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic watchdog_overflow_irq_in,
    input wire logic wdt_mode1_in,
    input wire logic software_break_instr_in,
    input wire logic irq_ack_in,
    input wire logic nmi_return_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic irq_req_out,
    input wire logic irq_nmi_out,
    input wire logic [15:0] vector_out,
    input wire logic accept_out,
    input wire logic ie_clear_out,
    input wire logic isp_load_out,
    input wire logic standby_release_out
);
    logic nmi_busy_q;
    // NMI service is not visible at the ports, so follow it here
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            nmi_busy_q <= 1'b0;
        else if (irq_ack_in && irq_req_out && irq_nmi_out)
            nmi_busy_q <= 1'b1;
        else if (nmi_return_in)
            nmi_busy_q <= 1'b0;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    a_break_vector: assert property (
        software_break_instr_in |=> accept_out && ie_clear_out
        && !isp_load_out && vector_out == 16'h003e)
        else $error("break not vectored as expected");
    a_nmi_present: assert property (
        watchdog_overflow_irq_in && wdt_mode1_in && !nmi_busy_q
        && !irq_req_out |-> ##2 irq_nmi_out)
        else $error("watchdog overflow not presented as nmi");
    a_nmi_vector: assert property (
        irq_req_out && irq_nmi_out && !$past(software_break_instr_in)
        |-> vector_out == 16'h0004)
        else $error("nmi vector wrong");
    a_ack_accepts: assert property (
        irq_ack_in && irq_req_out && !software_break_instr_in
        |=> accept_out && ie_clear_out && !irq_req_out)
        else $error("acknowledge did not accept");
    a_isp_copy: assert property (
        irq_ack_in && irq_req_out && !irq_nmi_out
        && !software_break_instr_in |=> isp_load_out)
        else $error("maskable accept did not load isp");
    a_standby_nmi: assert property (
        (watchdog_overflow_irq_in && wdt_mode1_in && !irq_req_out
        ##1 !irq_ack_in) |=> standby_release_out)
        else $error("nmi did not release standby");
    a_unmapped_read: assert property (
        reg_rd_in && reg_sel_in > 3'h5 |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_wdt_flag_mode1: assert property (
        reg_rd_in && reg_sel_in == 3'h0 && wdt_mode1_in
        |=> !reg_rdata_out[0])
        else $error("watchdog flag readable in mode 1");
endmodule : vic_props
bind vic_controller vic_props u_props (.ref_clk_in, .nrst_in,
    .watchdog_overflow_irq_in, .wdt_mode1_in, .software_break_instr_in,
    .irq_ack_in, .nmi_return_in, .reg_sel_in, .reg_rd_in, .reg_rdata_out,
    .irq_req_out, .irq_nmi_out, .vector_out, .accept_out, .ie_clear_out,
    .isp_load_out, .standby_release_out);

/* test/vic_core_model.sv */
// Core model: acknowledges requests and runs short service routines
`timescale 1ns/1ps
module vic_core_model
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic irq_req_in,
    input wire logic ie_clear_in,
    input wire logic isp_load_in,
    input wire logic isp_value_in,
    input wire logic hold_in,
    input wire logic [3:0] ack_wait_in,
    output logic irq_ack_out,
    output logic ie_out,
    output logic isp_out
);
    logic [3:0] wait_q;
    logic [4:0] svc_q;
    logic ie_q;
    // Hold lets several requests pend before arbitration starts
    assign ie_out = ie_q && !hold_in;
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            wait_q <= 4'h0;
        else
            wait_q <= (irq_req_in && !irq_ack_out) ? wait_q + 4'h1 : 4'h0;
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_ack_out <= 1'b0;
        else
            irq_ack_out <= irq_req_in && !irq_ack_out && wait_q >= ack_wait_in;
    end
    // Service ends by restoring enable and priority, as a return would
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ie_q <= 1'b1;
            isp_out <= 1'b1;
            svc_q <= 5'h00;
        end
        else if (ie_clear_in)
        begin
            ie_q <= 1'b0;
            svc_q <= 5'h14;
            isp_out <= isp_load_in ? isp_value_in : isp_out;
        end
        else if (svc_q == 5'h01)
        begin
            ie_q <= 1'b1;
            isp_out <= 1'b1;
            svc_q <= 5'h00;
        end
        else if (svc_q != 5'h00)
            svc_q <= svc_q - 5'h01;
    end
endmodule : vic_core_model

/* test/testbench.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module testbench;
    logic ref_clk_in, nrst_in, wdt, mode1, software_break_instr, nret, hold, ack, ie, in_service_priority;
    logic wr, rd, word, bitw, req, nmi, acc, iec, ispl, ispv, stby, ip;
    logic [2:0] pins, sel, bidx, rise, fall;
    logic [6:0] pul;
    logic [9:0] prio;
    logic [3:0] ack_wait;
    logic [15:0] wdata, rdata, vec, ev;
    logic [31:0] seed = 32'he0c7_3976;
    logic [15:0] exp_q[$];
    logic [15:0] vtab [10] = '{16'h0004, 16'h0008, 16'h000a, 16'h000c,
        16'h0018, 16'h001a, 16'h001c, 16'h0028, 16'h002a, 16'h002c};
    int err_count = 0;
    int checked = 0;
    vic_controller dut (.ref_clk_in, .nrst_in, .watchdog_overflow_irq_in(wdt),
        .wdt_mode1_in(mode1), .pin_edge_irq_in(pins), .pin_rise_en_in(rise),
        .pin_fall_en_in(fall), .serial_rx_error_irq_in(pul[0]),
        .serial_rx_done_irq_in(pul[1]), .three_wire_done_irq_in(pul[2]),
        .serial_tx_done_irq_in(pul[3]), .conversion_done_irq_in(pul[4]),
        .timer_a_match_irq_in(pul[5]), .timer_b_match_irq_in(pul[6]),
        .source_priority_flag_in(prio), .global_irq_enable_in(ie),
        .in_service_priority_in(in_service_priority), .software_break_instr_in(software_break_instr),
        .irq_ack_in(ack), .nmi_return_in(nret), .reg_sel_in(sel),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_word_in(word), .reg_bit_in(bitw),
        .reg_bit_idx_in(bidx), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .irq_req_out(req), .irq_nmi_out(nmi), .vector_out(vec),
        .accept_out(acc), .ie_clear_out(iec), .isp_load_out(ispl),
        .isp_value_out(ispv), .standby_release_out(stby));
    vic_core_model core (.ref_clk_in, .nrst_in, .irq_req_in(req),
        .ie_clear_in(iec), .isp_load_in(ispl), .isp_value_in(ispv),
        .hold_in(hold), .ack_wait_in(ack_wait), .irq_ack_out(ack),
        .ie_out(ie), .isp_out(in_service_priority));
    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string what, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : cyc
    task automatic reg_op(input logic w, wd, bt, input logic [2:0] s, bi,
        input logic [15:0] d);
        @(posedge ref_clk_in);
        {wr, rd, word, bitw, sel, bidx, wdata} <= {w, !w, wd, bt, s, bi, d};
        @(posedge ref_clk_in);
        {wr, rd} <= 2'b00;
    endtask : reg_op
    task automatic rd_chk(input logic [2:0] s, input logic wd,
        input logic [15:0] e);
        logic [15:0] m;
        m = wd ? 16'hffff : 16'h00ff;
        reg_op(1'b0, wd, 1'b0, s, 3'h0, 16'h0000);
        @(posedge ref_clk_in);
        chk("read data", e, rdata & m);
    endtask : rd_chk
    task automatic pulse(input logic [6:0] p, input logic w, b, r);
        @(posedge ref_clk_in);
        {pul, wdt, software_break_instr, nret} <= {p, w, b, r};
        @(posedge ref_clk_in);
        {pul, wdt, software_break_instr, nret} <= '0;
    endtask : pulse
    task automatic drain();
        int n = 0;
        while (exp_q.size() != 0 && n < 600)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        chk("accepts left", 16'h0000, 16'(exp_q.size()));
        cyc(25);
    endtask : drain
    always @(posedge ref_clk_in)
    begin
        #1;
        if (acc === 1'b1 && exp_q.size() == 0)
            chk("spare accept", 16'h0000, vec);
        else if (acc === 1'b1)
        begin
            ev = exp_q.pop_front();
            chk("vector", ev, vec);
            // Priority flag of the source taken; the NMI always loads 0
            ip = 1'b0;
            for (int i = 0; i < 10; i++)
                ip |= vtab[i] == ev && !mode1 && prio[i];
            if (ev != 16'h003e)
                chk("isp value", {15'h0, ip}, {15'h0, ispv});
        end
    end
    // Tests need about 1500 cycles; this leaves a wide margin
    initial
    begin
        #100_000;
        err_count++;
        close_out();
    end
    initial
    begin
        int n;
        logic [31:0] rnd;
        {wdt, mode1, software_break_instr, nret, hold, wr, rd, word, bitw, nrst_in} = '0;
        {pins, sel, bidx, pul, prio, ack_wait, wdata} = '0;
        {rise, fall} = '1;
        cyc(12);
        nrst_in <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk(3'(i), 1'b0, (i > 2 && i < 6) ? 16'h00ff : 16'h0000);
        reg_op(1'b1, 1'b0, 1'b0, 3'h2, 3'h0, 16'h001c);
        rd_chk(3'h2, 1'b0, 16'h001c);
        chk("standby", 16'h0000, {15'h0, stby});
        reg_op(1'b1, 1'b1, 1'b0, 3'h3, 3'h0, 16'he3e2);
        rd_chk(3'h3, 1'b1, 16'he3e2);
        exp_q.push_back(16'h0028);
        reg_op(1'b1, 1'b0, 1'b1, 3'h5, 3'h2, 16'h0000);
        cyc(2);
        #1 chk("standby", 16'h0001, {15'h0, stby});
        drain();
        // Software clear meets a hardware set in the same cycle
        fork
            reg_op(1'b1, 1'b0, 1'b0, 3'h2, 3'h0, 16'h0000);
            pulse(7'h40, 1'b0, 1'b0, 1'b0);
        join
        rd_chk(3'h2, 1'b0, 16'h0010);
        mode1 <= 1'b1;
        reg_op(1'b1, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0001);
        rd_chk(3'h0, 1'b0, 16'h0000);
        mode1 <= 1'b0;
        reg_op(1'b1, 1'b0, 1'b0, 3'h6, 3'h0, 16'h00ff);
        rd_chk(3'h6, 1'b0, 16'h0000);
        rd_chk(3'h7, 1'b1, 16'h0000);
        reg_op(1'b1, 1'b0, 1'b0, 3'h2, 3'h0, 16'h0000);
        reg_op(1'b1, 1'b0, 1'b0, 3'h5, 3'h0, 16'h00e3);
        for (int g = 0; g < 2; g++)
        begin
            prio <= {10{g[0]}};
            ack_wait <= 4'(xs());
            exp_q.push_back(16'h002a);
            pulse(7'h20, 1'b0, 1'b0, 1'b0);
            n = 0;
            while (req !== 1'b1 && n < 40)
            begin
                @(posedge ref_clk_in);
                #1 n++;
            end
            chk("latency", 16'(7 + g), 16'(n));
            drain();
        end
        for (int r = 0; r < 3; r++)
        begin
            rnd = xs();
            {hold, prio, ack_wait} <= {1'b1, rnd[9:0], rnd[13:10]};
            {rise, fall} <= rnd[20:15];
            pins <= ~pins;
            pulse(rnd[14] ? 7'h7b : 7'h7d, 1'b1, 1'b0, 1'b0);
            for (int p = 0; p < 2; p++)
                for (int i = 0; i < 10; i++)
                    if (rnd[i] == p[0] && (i == 0 || i > 3 ||
                        (pins[i-1] ? rise[i-1] : fall[i-1])))
                        exp_q.push_back(vtab[i]);
            cyc(6);
            hold <= 1'b0;
            drain();
        end
        {mode1, hold} <= 2'b11;
        exp_q.push_back(16'h003e);
        exp_q.push_back(16'h0004);
        pulse(7'h00, 1'b0, 1'b1, 1'b0);
        cyc(3);
        pulse(7'h00, 1'b1, 1'b0, 1'b0);
        cyc(30);
        pulse(7'h00, 1'b1, 1'b0, 1'b0);
        pulse(7'h00, 1'b1, 1'b0, 1'b0);
        cyc(30);
        exp_q.push_back(16'h0004);
        pulse(7'h00, 1'b0, 1'b0, 1'b1);
        drain();
        pulse(7'h00, 1'b0, 1'b0, 1'b1);
        cyc(30);
        close_out();
    end
endmodule : testbench
